// ---- hw/intc_map.vh ----
`ifndef INTC_MAP_VH
`define INTC_MAP_VH
// register word addresses (byte address = index * 4)
`define ADDR_ENABLE 4'h0
`define ADDR_PRIO_LOW 4'h1
`define ADDR_PRIO_HIGH 4'h2
`define ADDR_TIMER_CTRL 4'h3
`define ADDR_FLAGS 4'h4
`define ADDR_STATUS 4'h5
// enable and priority register fields
`define EN_GLOBAL_BIT 7
`define PRIO_MASK 8'h3F
// flag register field positions
`define FLG_EXT0 0
`define FLG_TMR0 1
`define FLG_EXT1 2
`define FLG_TMR1 3
`define FLG_RX 4
`define FLG_TX 5
`define FLG_TMR2 6
`define FLG_TMR2X 7
// timer control fields
`define TC_EXT0_TYPE 0
`define TC_EXT1_TYPE 2
// vectors, per polling order
`define VEC_EXT0 16'h0003
`define VEC_TMR0 16'h000B
`define VEC_EXT1 16'h0013
`define VEC_TMR1 16'h001B
`define VEC_SER 16'h0023
`define VEC_TMR2 16'h002B
// machine cycle: 12 oscillator periods = 6 states x 2 phases
`define PHASES_PER_CYCLE 4'd12
`define SAMPLE_PHASE 4'd9
`define CALL_CYCLES 2'd2
`endif

// ---- hw/four_level_interrupt_controller.v ----
`timescale 1ns/1ps
`default_nettype none
`include "intc_map.vh"
module four_level_interrupt_controller (
    // clock and reset
    input wire clk_sys,
    input wire rst,
    // avalon-mm slave
    input wire [3:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    output reg [31:0] readdata,
    output wire waitrequest,
    // external request pins, active low
    input wire ext0RequestPinN,
    input wire ext1RequestPinN,
    // hardware flag set events
    input wire timer0OverflowSet,
    input wire timer1OverflowSet,
    input wire timer2OverflowSet,
    input wire timer2ExternalSet,
    input wire serialRxDoneSet,
    input wire serialTxDoneSet,
    // core sequencer
    input wire instrLastCycle,
    input wire instrReturnFromInterrupt,
    input wire instrPlainReturn,
    input wire instrWritesEnableOrPriority,
    // call request to core
    output reg callRequest,
    output reg [15:0] callVector,
    output reg callPushPc,
    output reg [1:0] serviceLevel,
    output wire [3:0] inProgress
);
    // ==========================================================
    // state
    // ==========================================================
    reg [3:0] phase_q;
    reg [7:0] enable_q;
    reg [7:0] prioLow_q;
    reg [7:0] prioHigh_q;
    reg [7:0] timerCtrl_q;
    reg [7:0] flags_q;
    reg [5:0] sampled_q;
    reg ext0Prev_q;
    reg ext1Prev_q;
    reg [3:0] inProg_q;
    reg [1:0] callCnt_q;
    reg [2:0] callSrc_q;
    reg blockNext_q;
    reg ack_q;
    reg [5:0] polled_q;
    reg rdDone_q;
    localparam ST_IDLE = 2'b01;
    localparam ST_CALL = 2'b10;
    reg [1:0] state_q;

    // reads take one wait state, writes none
    assign waitrequest = read && !rdDone_q;
    assign inProgress = inProg_q;

    // ==========================================================
    // functions
    // ==========================================================
    function [1:0] levelOf;
        input [2:0] src;
        begin
            levelOf = {prioHigh_q[src], prioLow_q[src]};
        end
    endfunction

    function [15:0] vectorOf;
        input [2:0] src;
        begin
            case (src)
                3'd0: vectorOf = `VEC_EXT0;
                3'd1: vectorOf = `VEC_TMR0;
                3'd2: vectorOf = `VEC_EXT1;
                3'd3: vectorOf = `VEC_TMR1;
                3'd4: vectorOf = `VEC_SER;
                default: vectorOf = `VEC_TMR2;
            endcase
        end
    endfunction

    // true if level lvl or any higher level is in progress
    function blockedAt;
        input [1:0] lvl;
        input [3:0] prog;
        begin
            blockedAt = |(prog >> lvl);
        end
    endfunction

    // drop the highest in-progress marker
    function [3:0] clearTop;
        input [3:0] prog;
        begin
            clearTop = prog;
            if (prog[3])
                clearTop[3] = 1'b0;
            else if (prog[2])
                clearTop[2] = 1'b0;
            else if (prog[1])
                clearTop[1] = 1'b0;
            else
                clearTop[0] = 1'b0;
        end
    endfunction

    // ==========================================================
    // phase counter
    // ==========================================================
    wire samplePhase = (phase_q == `SAMPLE_PHASE);
    wire cycleEnd = (phase_q == `PHASES_PER_CYCLE - 4'd1);
    always @(posedge clk_sys) begin
        if (rst)
            phase_q <= 4'h0;
        else if (cycleEnd)
            phase_q <= 4'h0;
        else
            phase_q <= phase_q + 4'h1;
    end

    // ==========================================================
    // arbitration on samples of previous cycle
    // ==========================================================
    reg [2:0] winSrc;
    reg [1:0] winLvl;
    reg winValid;
    integer i;
    always @* begin
        winSrc = 3'd0;
        winLvl = 2'd0;
        winValid = 1'b0;
        // strict > keeps earliest source within a level
        for (i = 0; i < 6; i = i + 1) begin
            if (polled_q[i] && enable_q[i] && !blockedAt(levelOf(i[2:0]), inProg_q)
                && (!winValid || levelOf(i[2:0]) > winLvl)) begin
                winValid = 1'b1;
                winSrc = i[2:0];
                winLvl = levelOf(i[2:0]);
            end
        end
    end

    // poll gates, split by cause
    wire globalOn = enable_q[`EN_GLOBAL_BIT];
    wire instrAllows = instrLastCycle && !instrReturnFromInterrupt
        && !instrWritesEnableOrPriority && !blockNext_q;
    wire callIdle = (state_q == ST_IDLE) && !ack_q;
    wire canVector = globalOn && winValid && instrAllows && callIdle;
    // poll decision once per cycle at its end
    wire takeCall = cycleEnd && canVector;

    // ==========================================================
    // bus decode
    // ==========================================================
    wire wrEnable = write && address == `ADDR_ENABLE;
    wire wrPrioLow = write && address == `ADDR_PRIO_LOW;
    wire wrPrioHigh = write && address == `ADDR_PRIO_HIGH;
    wire wrFlags = write && address == `ADDR_FLAGS;
    wire wrTc = write && address == `ADDR_TIMER_CTRL;
    // first cycle of a read: capture data, hold off
    wire rdFirst = read && !rdDone_q;

    // ==========================================================
    // flags
    // ==========================================================
    wire ext0Edge = timerCtrl_q[`TC_EXT0_TYPE];
    wire ext1Edge = timerCtrl_q[`TC_EXT1_TYPE];
    reg [7:0] flagsD;
    always @* begin
        flagsD = flags_q;
        if (wrFlags)
            flagsD = writedata[7:0];
        if (ack_q && callSrc_q == 3'd1)
            flagsD[`FLG_TMR0] = 1'b0;
        if (ack_q && callSrc_q == 3'd3)
            flagsD[`FLG_TMR1] = 1'b0;
        if (ack_q && callSrc_q == 3'd0 && ext0Edge)
            flagsD[`FLG_EXT0] = 1'b0;
        if (ack_q && callSrc_q == 3'd2 && ext1Edge)
            flagsD[`FLG_EXT1] = 1'b0;
        // sets win over any clear
        if (timer0OverflowSet)
            flagsD[`FLG_TMR0] = 1'b1;
        if (timer1OverflowSet)
            flagsD[`FLG_TMR1] = 1'b1;
        if (timer2OverflowSet)
            flagsD[`FLG_TMR2] = 1'b1;
        if (timer2ExternalSet)
            flagsD[`FLG_TMR2X] = 1'b1;
        if (serialRxDoneSet)
            flagsD[`FLG_RX] = 1'b1;
        if (serialTxDoneSet)
            flagsD[`FLG_TX] = 1'b1;
        if (samplePhase) begin
            if (!ext0Edge)
                flagsD[`FLG_EXT0] = !ext0RequestPinN;
            else if (ext0Prev_q && !ext0RequestPinN)
                flagsD[`FLG_EXT0] = 1'b1;
            if (!ext1Edge)
                flagsD[`FLG_EXT1] = !ext1RequestPinN;
            else if (ext1Prev_q && !ext1RequestPinN)
                flagsD[`FLG_EXT1] = 1'b1;
        end
    end

    // per-source requests in polling order
    wire [5:0] srcRequests = {flagsD[`FLG_TMR2] | flagsD[`FLG_TMR2X],
        flagsD[`FLG_RX] | flagsD[`FLG_TX],
        flagsD[`FLG_TMR1],
        flagsD[`FLG_EXT1],
        flagsD[`FLG_TMR0],
        flagsD[`FLG_EXT0]};

    always @(posedge clk_sys) begin
        if (rst) begin
            flags_q <= 8'h00;
            sampled_q <= 6'h00;
            polled_q <= 6'h00;
            ext0Prev_q <= 1'b1;
            ext1Prev_q <= 1'b1;
        end else begin
            flags_q <= flagsD;
            if (samplePhase) begin
                ext0Prev_q <= ext0RequestPinN;
                ext1Prev_q <= ext1RequestPinN;
                sampled_q <= srcRequests;
            end
            // decision at cycle end sees last cycle's samples
            if (cycleEnd)
                polled_q <= sampled_q;
        end
    end

    // ==========================================================
    // configuration registers
    // ==========================================================
    always @(posedge clk_sys) begin
        if (rst) begin
            enable_q <= 8'h00;
            prioLow_q <= 8'h00;
            prioHigh_q <= 8'h00;
            timerCtrl_q <= 8'h00;
        end else begin
            if (wrEnable)
                enable_q <= writedata[7:0];
            if (wrPrioLow)
                prioLow_q <= writedata[7:0] & `PRIO_MASK;
            if (wrPrioHigh)
                prioHigh_q <= writedata[7:0] & `PRIO_MASK;
            if (wrTc)
                timerCtrl_q <= writedata[7:0];
        end
    end

    // two more instructions must finish after such an instruction before a call
    always @(posedge clk_sys) begin
        if (rst)
            blockNext_q <= 1'b0;
        else if (instrLastCycle && cycleEnd)
            blockNext_q <= instrReturnFromInterrupt || instrWritesEnableOrPriority;
    end

    // ==========================================================
    // call sequence and in-progress markers
    // ==========================================================
    always @(posedge clk_sys) begin
        if (rst) begin
            inProg_q <= 4'h0;
            state_q <= ST_IDLE;
            callCnt_q <= 2'd0;
            callSrc_q <= 3'd0;
            ack_q <= 1'b0;
            callRequest <= 1'b0;
            callVector <= 16'h0000;
            callPushPc <= 1'b0;
            serviceLevel <= 2'd0;
        end else begin
            ack_q <= 1'b0;
            callPushPc <= 1'b0;
            // interrupt return ends the highest active level
            if (instrReturnFromInterrupt && instrLastCycle && cycleEnd)
                inProg_q <= clearTop(inProg_q);
            // a plain return leaves markers untouched
            case (state_q)
                ST_IDLE: begin
                    if (takeCall) begin
                        state_q <= ST_CALL;
                        callCnt_q <= 2'd0;
                        callSrc_q <= winSrc;
                        ack_q <= 1'b1;
                        callRequest <= 1'b1;
                        callPushPc <= 1'b1;
                        callVector <= vectorOf(winSrc);
                        serviceLevel <= winLvl;
                        inProg_q[winLvl] <= 1'b1;
                    end
                end
                ST_CALL: begin
                    if (cycleEnd) begin
                        if (callCnt_q == `CALL_CYCLES - 2'd1) begin
                            state_q <= ST_IDLE;
                            callRequest <= 1'b0;
                        end
                        callCnt_q <= callCnt_q + 2'd1;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // read handshake
    // ==========================================================
    // data registered on the first cycle, handed over on the second
    always @(posedge clk_sys) begin
        if (rst)
            rdDone_q <= 1'b0;
        else
            rdDone_q <= rdFirst;
    end

    // ==========================================================
    // read data
    // ==========================================================
    always @(posedge clk_sys) begin
        if (rst)
            readdata <= 32'h0000_0000;
        else if (rdFirst) begin
            case (address)
                `ADDR_ENABLE: readdata <= {24'h000000, enable_q};
                `ADDR_PRIO_LOW: readdata <= {24'h000000, prioLow_q};
                `ADDR_PRIO_HIGH: readdata <= {24'h000000, prioHigh_q};
                `ADDR_TIMER_CTRL: readdata <= {24'h000000, timerCtrl_q};
                `ADDR_FLAGS: readdata <= {24'h000000, flags_q};
                `ADDR_STATUS: readdata <= {24'h000000, 2'b00, serviceLevel, inProg_q};
                default: readdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule // four_level_interrupt_controller
`default_nettype wire

// ---- tb/intc_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module intc_checker (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // core status
    input wire logic instrLastCycle,
    input wire logic instrReturnFromInterrupt,
    input wire logic instrWritesEnableOrPriority,
    // call side
    input wire logic callRequest,
    input wire logic [15:0] callVector,
    input wire logic callPushPc,
    input wire logic [1:0] serviceLevel,
    input wire logic [3:0] inProgress
);
    // ==========
    // machine phase
    logic [3:0] ph_q;
    always_ff @(posedge clk_sys) begin
        ph_q <= (rst || ph_q == 4'hB) ? 4'h0 : ph_q + 4'h1;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence callStart;
        $rose(callRequest);
    endsequence
    // ==========
    // call checks
    a_push_at_start: assert property (callStart |-> callPushPc) else $error("no push at call");
    a_push_single: assert property (callPushPc |=> !callPushPc) else $error("push too long");
    a_call_two_cycles: assert property (callStart |-> ##23 callRequest) else $error("call short");
    a_call_on_phase: assert property (callStart |-> ph_q == 4'h0) else $error("call off phase");
    a_vector_legal: assert property (callStart |-> callVector inside {16'h0003, 16'h000B, 16'h0013,
        16'h001B, 16'h0023, 16'h002B}) else $error("bad vector");
    a_level_marked: assert property (callStart |-> inProgress[serviceLevel]) else $error("unmarked");
    a_equal_blocks: assert property (callStart |-> ($past(inProgress) >> serviceLevel) == 4'h0)
        else $error("level busy");
    a_last_cycle: assert property (callStart |-> $past(instrLastCycle)) else $error("mid instr");
    a_kind_blocks: assert property (callStart |-> !$past(instrReturnFromInterrupt)
        && !$past(instrWritesEnableOrPriority)) else $error("blocked kind");
endmodule // intc_checker
bind four_level_interrupt_controller intc_checker chk (.clk_sys, .rst, .instrLastCycle,
    .instrReturnFromInterrupt, .instrWritesEnableOrPriority, .callRequest, .callVector, .callPushPc,
    .serviceLevel, .inProgress);
`default_nettype wire

// ---- tb/core_seq_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module core_seq_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // bench commands
    input wire logic stall,
    input wire logic [1:0] kind,
    // instruction status
    output logic instrLastCycle,
    output logic instrReturnFromInterrupt,
    output logic instrPlainReturn,
    output logic instrWritesEnableOrPriority
);
    logic [3:0] ph_q;
    // ==========
    // one instruction per machine cycle
    always_ff @(posedge clk_sys) begin
        ph_q <= (rst || ph_q == 4'hB) ? 4'h0 : ph_q + 4'h1;
        if (rst) begin
            instrLastCycle <= 1'b0;
            instrReturnFromInterrupt <= 1'b0;
            instrPlainReturn <= 1'b0;
            instrWritesEnableOrPriority <= 1'b0;
        end else if (ph_q == 4'hB) begin
            instrLastCycle <= !stall;
            instrReturnFromInterrupt <= kind == 2'd1;
            instrPlainReturn <= kind == 2'd2;
            instrWritesEnableOrPriority <= kind == 2'd3;
        end
    end
endmodule // core_seq_model
`default_nettype wire

// ---- tb/four_level_interrupt_controller_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "intc_map.vh"
module four_level_interrupt_controller_bench;
    logic clk_sys = 0, rst = 1, read = 0, write = 0, stall = 0;
    logic [1:0] pinN = 2'h3, kind = 2'h0;
    logic [3:0] address = 4'h0;
    logic [7:0] setPulse = 8'h00;
    logic [31:0] writedata = 32'h0;
    wire [31:0] readdata;
    wire [15:0] callVector;
    wire [3:0] inProgress;
    wire [1:0] serviceLevel;
    wire waitrequest, callRequest, callPushPc;
    wire instrLastCycle, instrReturnFromInterrupt, instrPlainReturn, instrWritesEnableOrPriority;
    int error_cnt = 0, compares = 0;
    always #2.5 clk_sys = ~clk_sys;
    four_level_interrupt_controller uut (.clk_sys, .rst, .address, .read, .write, .writedata, .readdata,
        .waitrequest, .ext0RequestPinN(pinN[0]), .ext1RequestPinN(pinN[1]), .timer0OverflowSet(setPulse[1]),
        .timer1OverflowSet(setPulse[3]), .timer2OverflowSet(setPulse[6]), .timer2ExternalSet(setPulse[7]),
        .serialRxDoneSet(setPulse[4]), .serialTxDoneSet(setPulse[5]), .instrLastCycle,
        .instrReturnFromInterrupt, .instrPlainReturn, .instrWritesEnableOrPriority, .callRequest,
        .callVector, .callPushPc, .serviceLevel, .inProgress);
    core_seq_model core (.clk_sys, .rst, .stall, .kind, .instrLastCycle, .instrReturnFromInterrupt,
        .instrPlainReturn, .instrWritesEnableOrPriority);
    // ==========
    // tasks
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        address <= a;
        writedata <= {24'h0, d};
        write <= 1;
        @(negedge clk_sys);
        while (waitrequest !== 1'b0) @(negedge clk_sys);
        @(posedge clk_sys);
        write <= 0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        address <= a;
        read <= 1;
        // settled at the falling edge, taken at the next rising one
        @(negedge clk_sys);
        while (waitrequest !== 1'b0) @(negedge clk_sys);
        chk("readdata", readdata, exp);
        @(posedge clk_sys);
        read <= 0;
        @(posedge clk_sys);
    endtask
    task automatic pulse(input int b);
        setPulse[b] <= 1;
        @(posedge clk_sys);
        setPulse <= 8'h00;
        @(posedge clk_sys);
    endtask
    task automatic instr(input logic [1:0] k);
        kind <= k;
        repeat (12) @(posedge clk_sys);
        kind <= 2'h0;
        repeat (24) @(posedge clk_sys);
    endtask
    task automatic expectCall(input logic want, input logic [15:0] vec, input logic [1:0] lvl);
        for (int n = 0; n < 60 && callRequest !== 1'b1; n++) @(negedge clk_sys);
        chk("callRequest", callRequest, want);
        if (want) chk("callVector", callVector, vec);
        if (want) chk("serviceLevel", serviceLevel, lvl);
        repeat (30) @(posedge clk_sys);
    endtask
    task automatic conclude;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #100us;
        error_cnt++;
        conclude();
    end
    // ==========
    // tests
    initial begin
        repeat (5) @(posedge clk_sys);
        rst <= 0;
        rd(`ADDR_STATUS, 0);
        wr(`ADDR_PRIO_LOW, 8'hFF);
        rd(`ADDR_PRIO_LOW, 32'h3F);
        rd(4'hF, 0);
        wr(`ADDR_PRIO_LOW, 8'h00);
        wr(`ADDR_TIMER_CTRL, 8'h05);
        wr(`ADDR_ENABLE, 8'hBF);
        $display("test registers done");
        for (int i = 0; i < 6; i++) begin
            if (i == 0 || i == 2) pinN[i / 2] <= 0;
            else pulse(i == 5 ? 6 : i);
            expectCall(1, 16'h0003 + 16'(8 * i), 0);
            rd(`ADDR_FLAGS, i == 4 ? 32'h10 : i == 5 ? 32'h40 : 0);
            pinN <= 2'h3;
            wr(`ADDR_FLAGS, 0);
            instr(1);
            rd(`ADDR_STATUS, 0);
        end
        $display("test vectors done");
        wr(`ADDR_ENABLE, 8'h3F);
        pulse(7);
        pulse(5);
        pulse(3);
        expectCall(0, 0, 0);
        wr(`ADDR_ENABLE, 8'hBF);
        expectCall(1, `VEC_TMR1, 0);
        instr(1);
        expectCall(1, `VEC_SER, 0);
        wr(`ADDR_FLAGS, 8'h80);
        instr(1);
        expectCall(1, `VEC_TMR2, 0);
        wr(`ADDR_FLAGS, 0);
        instr(1);
        $display("test polling order done");
        wr(`ADDR_PRIO_LOW, 8'h22);
        wr(`ADDR_PRIO_HIGH, 8'h20);
        pulse(1);
        expectCall(1, `VEC_TMR0, 1);
        pulse(4);
        expectCall(0, 0, 0);
        pulse(6);
        expectCall(1, `VEC_TMR2, 3);
        instr(2);
        rd(`ADDR_STATUS, 32'h3A);
        wr(`ADDR_FLAGS, 8'h10);
        instr(1);
        rd(`ADDR_STATUS, 32'h32);
        expectCall(0, 0, 0);
        instr(1);
        expectCall(1, `VEC_SER, 0);
        wr(`ADDR_FLAGS, 0);
        instr(1);
        $display("test nesting done");
        stall <= 1;
        repeat (12) @(posedge clk_sys);
        pulse(3);
        expectCall(0, 0, 0);
        wr(`ADDR_FLAGS, 0);
        repeat (24) @(posedge clk_sys);
        stall <= 0;
        expectCall(0, 0, 0);
        pulse(3);
        expectCall(1, `VEC_TMR1, 0);
        instr(1);
        wr(`ADDR_TIMER_CTRL, 0);
        pinN[1] <= 0;
        expectCall(1, `VEC_EXT1, 0);
        rd(`ADDR_FLAGS, 32'h4);
        pinN[1] <= 1;
        repeat (24) @(posedge clk_sys);
        rd(`ADDR_FLAGS, 0);
        instr(1);
        expectCall(0, 0, 0);
        $display("test blocking done");
        conclude();
    end
endmodule // four_level_interrupt_controller_bench
`default_nettype wire
